// File: pkg/ufs_params.svh
// constants for the user flash store: offsets, fields, resets and timing
// Operation
// - 512 words of 16 bits at 9-bit word addresses 000h to 1FFh.
// - the lower sector is 000h-0FFh and the upper sector is 100h-1FFh.
// - erase clears one whole sector; a full clear takes two erases.
// - erase or program of one sector leaves the other sector unchanged.
// - words move up to 16 bits wide; user logic handles narrower widths.
// - separate program and erase requests; the store shows busy.
// - a built-in oscillator can be routed out to clock the user logic.
// - address and data pass serially in a configurable shift order.
`ifndef UFS_PARAMS_SVH
`define UFS_PARAMS_SVH
`define UFS_WORDS 512
`define UFS_AW 9
`define UFS_DW 16
`define UFS_SECT_WORDS 256
`define UFS_ERASED 16'hffff
`define UFS_REG_CTRL 8'h00
`define UFS_REG_STATUS 8'h04
`define UFS_REG_ADDR 8'h08
`define UFS_REG_DATA 8'h0c
`define UFS_CTRL_LSB_FIRST 0
`define UFS_CTRL_OSC_ROUTE 1
`define UFS_CTRL_RESET 2'h0
`define UFS_STAT_BUSY 0
`define UFS_STAT_ERASING 1
`define UFS_CLK_MHZ 25
`define UFS_PROG_US 40
`define UFS_ERASE_US 500
`define UFS_OSC_DIV 2
`endif

// File: pkg/ufs_pkg.sv
// types shared by the user flash store modules
`default_nettype none
package ufs_pkg;
   typedef enum logic [1:0] {
      st_idle,
      st_prog,
      st_erase
   } ufs_state_t;
endpackage
`default_nettype wire

// File: pkg/ufs_osc_if.sv
// carrier between the flash store core and its oscillator
`timescale 1ns/1ps
`default_nettype none
interface ufs_osc_if;
   logic route;
   logic osc;
   modport core (output route, input osc);
   modport osc_end (input route, output osc);
endinterface
`default_nettype wire

// File: hdl/ufs_osc.sv
// built-in oscillator: divided clock toggle, gated onto the array
`timescale 1ns/1ps
`default_nettype none
`include "ufs_params.svh"
module ufs_osc #(
   parameter int DIV = `UFS_OSC_DIV
) (
   input wire logic i_clk,      // system clock
   input wire logic i_reset,    // synchronous reset
   ufs_osc_if.osc_end osc_if    // route request in, oscillator out
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic tick;
   logic osc_q;
   logic osc_d;

   generate
      if (DIV < 1)
      begin : g_bad
         $error("ufs_osc: DIV must be at least 1");
      end
   endgenerate

   // tick is a one-cycle enable; the output only toggles on it
   always_comb
   begin
      tick = (cnt_q == CW'(DIV - 1));
      cnt_d = tick ? '0 : cnt_q + 1'b1;
      osc_d = osc_if.route ? (tick ? ~osc_q : osc_q) : 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cnt_q <= '0;
         osc_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         osc_q <= osc_d;
      end
   end

   assign osc_if.osc = osc_q;
endmodule
`default_nettype wire

// File: hdl/ufs_top.sv
// user flash store core: word array, serial ports, program/erase, wishbone
`timescale 1ns/1ps
`default_nettype none
`include "ufs_params.svh"
module ufs_top #(
   parameter int ERASE_CYC = `UFS_ERASE_US * `UFS_CLK_MHZ,
   parameter int OSC_DIV = `UFS_OSC_DIV
) (
   input wire logic i_clk,            // system clock, 25 MHz
   input wire logic i_reset,          // synchronous reset, active high
   input wire logic i_wb_cyc,         // wishbone cycle
   input wire logic i_wb_stb,         // wishbone strobe
   input wire logic i_wb_we,          // wishbone write
   input wire logic [7:0] i_wb_adr,   // wishbone byte address
   input wire logic [3:0] i_wb_sel,   // wishbone byte lanes
   input wire logic [31:0] i_wb_dat,  // wishbone write data
   output logic [31:0] o_wb_dat,      // wishbone read data
   output logic o_wb_ack,             // wishbone acknowledge
   input wire logic i_arclk,          // address shift clock
   input wire logic i_arshft,         // address shift enable
   input wire logic i_ardin,          // address serial in
   input wire logic i_drclk,          // data clock
   input wire logic i_drshft,         // 1 shift data, 0 load word
   input wire logic i_drdin,          // data serial in
   output logic o_drdout,             // data serial out
   input wire logic i_program,        // program request, rising edge
   input wire logic i_erase,          // sector erase request, rising edge
   output logic o_busy,               // program or erase in progress
   output logic o_osc                 // oscillator to the array
);
   localparam int PROG_CYC = `UFS_PROG_US * `UFS_CLK_MHZ;
   localparam int TW = $clog2(ERASE_CYC + 1);
   localparam int AW = `UFS_AW;
   localparam int DW = `UFS_DW;

   generate
      if (ERASE_CYC < `UFS_SECT_WORDS + 1 || PROG_CYC >= ERASE_CYC)
      begin : g_bad
         $error("ufs_top: erase time too short for a sector walk");
      end
   endgenerate

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [DW-1:0] mem_q [0:`UFS_WORDS-1];
   logic mem_we;
   logic [AW-1:0] mem_wa;
   logic [DW-1:0] mem_wd;

   always_ff @(posedge i_clk)
   begin
      if (mem_we)
         mem_q[mem_wa] <= mem_wd;
   end

   // ---------------------------------------------------------------
   // serial ports and program/erase sequencer
   // ---------------------------------------------------------------
   ufs_pkg::ufs_state_t st_q;
   ufs_pkg::ufs_state_t st_d;
   logic [AW-1:0] areg_q;
   logic [AW-1:0] areg_d;
   logic [DW-1:0] dreg_q;
   logic [DW-1:0] dreg_d;
   logic [TW-1:0] tmr_q;
   logic [TW-1:0] tmr_d;
   logic [8:0] wcnt_q;
   logic [8:0] wcnt_d;
   logic sec_q;
   logic sec_d;
   logic dout_q;
   logic dout_d;
   logic arclk_q;
   logic drclk_q;
   logic prog_q;
   logic erase_q;
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic lsb_first;

   assign lsb_first = ctrl_q[`UFS_CTRL_LSB_FIRST];

   always_comb
   begin
      st_d = st_q;
      areg_d = areg_q;
      dreg_d = dreg_q;
      tmr_d = tmr_q;
      wcnt_d = wcnt_q;
      sec_d = sec_q;
      mem_we = 1'b0;
      mem_wa = areg_q;
      mem_wd = mem_q[areg_q] & dreg_q;
      case (st_q)
         ufs_pkg::st_idle:
         begin
            // serial shifts and loads only happen while idle so a running
            // program keeps its target
            if (i_arclk && !arclk_q && i_arshft)
               areg_d = lsb_first ? {i_ardin, areg_q[AW-1:1]}
                                  : {areg_q[AW-2:0], i_ardin};
            if (i_drclk && !drclk_q)
            begin
               if (i_drshft)
                  dreg_d = lsb_first ? {i_drdin, dreg_q[DW-1:1]}
                                     : {dreg_q[DW-2:0], i_drdin};
               else
               begin
                  dreg_d = mem_q[areg_q];
                  areg_d = areg_q + 1'b1;
               end
            end
            if (i_program && !prog_q)
            begin
               st_d = ufs_pkg::st_prog;
               tmr_d = TW'(PROG_CYC - 1);
            end
            else if (i_erase && !erase_q)
            begin
               st_d = ufs_pkg::st_erase;
               tmr_d = TW'(ERASE_CYC - 1);
               wcnt_d = '0;
               sec_d = areg_q[AW-1];
            end
         end
         ufs_pkg::st_prog:
         begin
            tmr_d = tmr_q - 1'b1;
            if (tmr_q == '0)
            begin
               // flash cells only clear bits; a set bit needs an erase
               mem_we = 1'b1;
               areg_d = areg_q + 1'b1;
               st_d = ufs_pkg::st_idle;
            end
         end
         ufs_pkg::st_erase:
         begin
            tmr_d = tmr_q - 1'b1;
            if (!wcnt_q[8])
            begin
               mem_we = 1'b1;
               mem_wa = {sec_q, wcnt_q[7:0]};
               mem_wd = `UFS_ERASED;
               wcnt_d = wcnt_q + 1'b1;
            end
            if (tmr_q == '0)
               st_d = ufs_pkg::st_idle;
         end
         default:
            st_d = ufs_pkg::st_idle;
      endcase
      dout_d = lsb_first ? dreg_d[0] : dreg_d[DW-1];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         st_q <= ufs_pkg::st_idle;
         areg_q <= '0;
         dreg_q <= '0;
         tmr_q <= '0;
         wcnt_q <= '0;
         sec_q <= 1'b0;
         dout_q <= 1'b0;
         arclk_q <= 1'b0;
         drclk_q <= 1'b0;
         prog_q <= 1'b0;
         erase_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         areg_q <= areg_d;
         dreg_q <= dreg_d;
         tmr_q <= tmr_d;
         wcnt_q <= wcnt_d;
         sec_q <= sec_d;
         dout_q <= dout_d;
         arclk_q <= i_arclk;
         drclk_q <= i_drclk;
         prog_q <= i_program;
         erase_q <= i_erase;
      end
   end

   assign o_busy = (st_q != ufs_pkg::st_idle);
   assign o_drdout = dout_q;

   // ---------------------------------------------------------------
   // wishbone slave
   // ---------------------------------------------------------------
   logic ack_q;
   logic ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;

   always_comb
   begin
      ack_d = i_wb_cyc && i_wb_stb && !ack_q;
      ctrl_d = ctrl_q;
      rdat_d = '0;
      // the write lands on the edge where the master sees ack high
      if (ack_q && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0]
          && i_wb_adr == `UFS_REG_CTRL)
         ctrl_d = i_wb_dat[1:0];
      case (i_wb_adr)
         `UFS_REG_CTRL: rdat_d = {30'h0, ctrl_q};
         `UFS_REG_STATUS: rdat_d = {30'h0, st_q == ufs_pkg::st_erase,
                                     o_busy};
         `UFS_REG_ADDR: rdat_d = {23'h0, areg_q};
         `UFS_REG_DATA: rdat_d = {16'h0, dreg_q};
         default: rdat_d = '0;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ack_q <= 1'b0;
         rdat_q <= '0;
         ctrl_q <= `UFS_CTRL_RESET;
      end
      else
      begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // ---------------------------------------------------------------
   // oscillator
   // ---------------------------------------------------------------
   ufs_osc_if osc_if ();
   assign osc_if.route = ctrl_q[`UFS_CTRL_OSC_ROUTE];
   assign o_osc = osc_if.osc;

   ufs_osc #(
      .DIV(OSC_DIV)
   ) ufs_osc_inst (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .osc_if(osc_if)
   );
endmodule
`default_nettype wire

// File: sim/ufs_checker.sv
// assertion checker watching the user flash store top ports
`timescale 1ns/1ps
`default_nettype none
module ufs_checker #(
   parameter int ERASE_CYC = 1200
) (
   input wire logic i_clk,     // clock
   input wire logic i_reset,   // reset
   input wire logic i_wb_cyc,  // cycle
   input wire logic i_wb_stb,  // strobe
   input wire logic o_wb_ack,  // ack
   input wire logic i_program, // program
   input wire logic i_erase,   // erase
   input wire logic o_busy,    // busy
   input wire logic o_osc      // oscillator
);
   int cnt_q;
   logic ers_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // busy length; cleared in reset so an aborted run leaves no residue
   always_ff @(posedge i_clk)
   begin
      cnt_q <= (o_busy && !i_reset) ? cnt_q + 1 : 0;
      // remember which request opened the busy period
      ers_q <= o_busy ? ers_q : (i_erase && !i_program);
   end
   a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
      |=> o_wb_ack) else $error("request not acknowledged");
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc)
      && $past(i_wb_stb)) else $error("ack without request");
   a_prog_start: assert property ($rose(i_program) && !o_busy
      |-> ##[1:2] o_busy) else $error("program did not raise busy");
   a_erase_start: assert property ($rose(i_erase) && !o_busy
      |-> ##[1:2] o_busy) else $error("erase did not raise busy");
   a_busy_cause: assert property ($rose(o_busy) |-> $past(i_program)
      || $past(i_erase) || $past(i_program, 2) || $past(i_erase, 2))
      else $error("busy without request");
   a_busy_len: assert property ($fell(o_busy) |-> cnt_q ==
      (ers_q ? ERASE_CYC : 1000)) else $error("busy length wrong");
   a_osc_hold: assert property ($changed(o_osc) |=> $stable(o_osc))
      else $error("oscillator toggled too fast");
endmodule
`default_nettype wire

// File: sim/ufs_user.sv
// model of the array-side user logic driving the serial store interface
`timescale 1ns/1ps
`default_nettype none
module ufs_user (
   input wire logic i_clk,    // clock
   input wire logic i_busy,   // store busy
   input wire logic i_drdout, // serial data out
   output logic o_arclk,      // address clock
   output logic o_arshft,     // address shift
   output logic o_ardin,      // address bit
   output logic o_drclk,      // data clock
   output logic o_drshft,     // shift or load
   output logic o_drdin,      // data bit
   output logic o_program,    // program request
   output logic o_erase       // erase request
);
   initial
   begin
      {o_arclk, o_arshft, o_ardin, o_drclk} = 4'h0;
      {o_drshft, o_drdin, o_program, o_erase} = 4'h0;
   end
   // --------
   // one clock pulse per bit, first bit first; released lines invert
   // --------
   task automatic put(input int n, input logic [15:0] v, input logic a,
      input logic s);
      for (int k = n - 1; k >= 0; k--)
      begin
         @(posedge i_clk);
         o_drshft <= s;
         o_arshft <= a;
         o_ardin <= v[k];
         o_drdin <= v[k];
         o_arclk <= a;
         o_drclk <= !a;
         @(posedge i_clk);
         o_arclk <= 1'b0;
         o_drclk <= 1'b0;
         o_ardin <= !v[k];
         o_drdin <= !v[k];
      end
   endtask
   task automatic get(output logic [15:0] w, input logic lsb);
      for (int i = 0; i < 16; i++)
      begin
         put(1, 16'h0000, 1'b0, i != 0);
         repeat (2) @(posedge i_clk);
         w[lsb ? i : 15 - i] = i_drdout;
      end
   endtask
   task automatic req(input logic e);
      @(posedge i_clk);
      o_program <= !e;
      o_erase <= e;
      @(posedge i_clk);
      o_program <= 1'b0;
      o_erase <= 1'b0;
   endtask
   task automatic idle();
      repeat (3) @(posedge i_clk);
      while (i_busy !== 1'b0)
         @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// File: sim/ufs_top_tb.sv
// self-checking bench for the user flash store
`timescale 1ns/1ps
`default_nettype none
module ufs_top_tb;
   localparam int ERASE_CYC = 1200;
   logic clk, rst, cyc, stb, we, ack, drdout, busy, osc;
   logic arclk, arshft, ardin, drclk, drshft, drdin, prog, ers;
   logic [7:0] adr;
   logic [31:0] dat, rdat, q;
   logic [15:0] w;
   int err_total, checks, cyc_n;
   ufs_top #(.ERASE_CYC(ERASE_CYC)) ufs_top_inst (.i_clk(clk),
      .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_arclk(arclk), .i_arshft(arshft),
      .i_ardin(ardin), .i_drclk(drclk), .i_drshft(drshft),
      .i_drdin(drdin), .o_drdout(drdout), .i_program(prog),
      .i_erase(ers), .o_busy(busy), .o_osc(osc));
   ufs_user ufs_user_inst (.i_clk(clk), .i_busy(busy), .i_drdout(drdout),
      .o_arclk(arclk), .o_arshft(arshft), .o_ardin(ardin),
      .o_drclk(drclk), .o_drshft(drshft), .o_drdin(drdin),
      .o_program(prog), .o_erase(ers));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("mismatch at %0t: %h not %h", $time, s, e);
      end
   endtask
   task automatic wb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'h3, wr, a, d};
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      r = rdat;
      {cyc, stb} <= 2'h0;
   endtask
   task automatic rd(input logic [8:0] a, input logic lsb);
      ufs_user_inst.put(9, {7'h00, a}, 1'b1, 1'b1);
      ufs_user_inst.get(w, lsb);
   endtask
   task automatic era(input logic [15:0] a);
      ufs_user_inst.put(9, a, 1'b1, 1'b1);
      ufs_user_inst.req(1'b1);
   endtask
   task automatic t_erase();
      era(16'h0000);
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q, 32'h3);
      ufs_user_inst.idle();
      era(16'h0100);
      ufs_user_inst.idle();
      rd(9'h0ff, 1'b0);
      chk(w, 16'hffff);
      rd(9'h1ff, 1'b0);
      chk(w, 16'hffff);
   endtask
   task automatic t_prog();
      ufs_user_inst.put(9, 16'h00ff, 1'b1, 1'b1);
      ufs_user_inst.put(16, 16'ha5c3, 1'b0, 1'b1);
      wb(1'b0, 8'h0c, 32'h0, q);
      chk(q, 32'ha5c3);
      ufs_user_inst.req(1'b0);
      ufs_user_inst.idle();
      ufs_user_inst.put(16, 16'h3c5a, 1'b0, 1'b1);
      ufs_user_inst.req(1'b0);
      ufs_user_inst.idle();
      wb(1'b0, 8'h08, 32'h0, q);
      chk(q, 32'h101);
      rd(9'h0ff, 1'b0);
      chk(w, 16'ha5c3);
      ufs_user_inst.get(w, 1'b0);
      chk(w, 16'h3c5a);
      era(16'h0000);
      ufs_user_inst.idle();
      rd(9'h0ff, 1'b0);
      chk(w, 16'hffff);
      rd(9'h100, 1'b0);
      chk(w, 16'h3c5a);
   endtask
   task automatic t_cfg();
      logic b;
      chk(osc, 1'b0);
      wb(1'b1, 8'h00, 32'h3, q);
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h3);
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h0);
      b = osc;
      repeat (4)
      begin
         repeat (2) @(posedge clk);
         chk(osc, !b);
         b = osc;
      end
      // address goes out lsb first too, so 100h is sent as 001h
      rd(9'h001, 1'b1);
      chk(w, 16'h3c5a);
   endtask
   task automatic finish_test();
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000)
      begin
         err_total++;
         finish_test();
      end
   end
   initial
   begin
      {rst, cyc, stb, we, adr, dat} = {1'b1, 43'h0};
      err_total = 0;
      checks = 0;
      cyc_n = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_erase();
      t_prog();
      t_cfg();
      finish_test();
   end
endmodule
bind ufs_top ufs_checker #(.ERASE_CYC(ERASE_CYC)) ufs_checker_inst (
   .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_program(i_program),
   .i_erase(i_erase), .o_busy(o_busy), .o_osc(o_osc));
`default_nettype wire
